// file: rtl/fdlp_pkg.sv
package fdlp_pkg;
    // line timing
    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned E1_LINE_KHZ      = 2048;
    localparam int unsigned T1_LINE_KHZ      = 1544;
    localparam int unsigned E1_FRAME_BITS    = 256;
    localparam int unsigned T1_FRAME_BITS    = 193;
    localparam int unsigned MF_FRAMES        = 16;
    localparam int unsigned T1_MF_FRAMES     = 12;
    localparam int unsigned FRAME_CNT_W      = 9;
    localparam int unsigned MF_CNT_W         = 4;
    localparam int unsigned BUF_DEPTH        = 2;
    // data-link rate select codes: 4, 8, 12, 16, 20 kHz = 1..5 bits per odd frame
    localparam logic [2:0]  DL_RATE_4K       = 3'h0;
    localparam logic [2:0]  DL_RATE_20K      = 3'h4;
    localparam logic [2:0]  DL_FIRST_BIT_E1  = 3'h3;
    localparam logic [8:0]  T1_DL_SLOT_BIT   = 9'h000;

    typedef enum logic [1:0] {
        FDLP_RX_SPLIT = 2'h0,
        FDLP_RX_NRZ   = 2'h1
    } fdlp_rx_fmt_t;

    typedef struct packed {
        logic         e1_mode;
        logic         nrz;
        logic         rx_nrz;
        logic         frame_pulse_sel;
        logic         crc_mf;
        logic [2:0]   dl_rate;
    } fdlp_cfg_t;

    typedef struct packed {
        logic         bit_val;
        logic         dl_bit;
    } fdlp_rx_word_t;
endpackage

// file: rtl/fdlp_buf.sv
`timescale 1ns/1ns
`default_nettype none
module fdlp_buf #(
    parameter int unsigned WIDTH = 2,
    parameter int unsigned DEPTH = 2
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             wr, rd;

    assign in_ready  = (cnt_q < (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;
    assign out_data  = mem_q[rp_q];

    always_comb begin
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        if (wr) begin
            wp_d = (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
        end
        if (rd) begin
            rp_d = (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
        end
        cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            if (wr) begin
                mem_q[wp_q] <= in_data;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/fdlp_port.sv
// Function
// - nrz selected: data on rail a at line clock rise, rail b idle
// - nrz off: rails a and b complementary dual-rail, updated on line clock rise
// - gapped link clock from line clock, 4 to 20 kHz selectable in e1, 4 kHz only in t1
// - received data stream out, changing on line clock rising edge
// - falling edge on align input sets transmit multiframe boundary, signalling or crc
// - align input held high: multiframe timing runs free
// - receive takes split-phase unipolar on both inputs or nrz on positive
// - line clock recovered from received signal and clocks in receive data
// - frame pulse select: positive pulse on first transmitted bit of frame
`timescale 1ns/1ns
`default_nettype none
module fdlp_port (
    // clock and reset
    input  wire logic           clock,
    input  wire logic           rst_n,
    // configuration
    input  wire fdlp_pkg::fdlp_cfg_t cfg,
    // transmit data from framer
    input  wire logic           tx_bit,
    output logic                tx_bit_taken,
    // line pins
    input  wire logic           rx_line_positive,
    input  wire logic           rx_line_negative,
    input  wire logic           tx_multiframe_align_n,
    output logic                tx_rail_a,
    output logic                tx_rail_b,
    output logic                extracted_clock,
    output logic                boundary_pulse_out,
    // data link pins
    output logic                rx_link_gapped_clock,
    output logic                rx_link_serial_out,
    // receiver stall
    input  wire logic           rx_link_ready,
    output logic                rx_overrun
);
    import fdlp_pkg::*;

    // three-stage synchronisers on pins; stage 1 feeds only stage 2
    logic [2:0] sp_q, sn_q, sa_q;
    logic       pos_s, neg_s, aln_n_s, pos_prev_q, neg_prev_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sp_q <= '0;
            sn_q <= '0;
            sa_q <= 3'h7;
        end else begin
            sp_q <= {sp_q[1:0], rx_line_positive};
            sn_q <= {sn_q[1:0], rx_line_negative};
            sa_q <= {sa_q[1:0], tx_multiframe_align_n};
        end
    end
    // a change counts once stages two and three agree
    logic pos_f_q, neg_f_q, aln_f_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pos_f_q <= 1'b0;
            neg_f_q <= 1'b0;
            aln_f_q <= 1'b1;
        end else begin
            if (sp_q[1] == sp_q[2]) pos_f_q <= sp_q[2];
            if (sn_q[1] == sn_q[2]) neg_f_q <= sn_q[2];
            if (sa_q[1] == sa_q[2]) aln_f_q <= sa_q[2];
        end
    end
    assign pos_s   = pos_f_q;
    assign neg_s   = neg_f_q;
    assign aln_n_s = aln_f_q;

    // line clock recovery: nco at line rate, phase reset on data transitions
    localparam int unsigned PH_W = 16;
    localparam logic [PH_W-1:0] E1_INC = PH_W'((E1_LINE_KHZ * 65536) / (CLK_MHZ * 1000));
    localparam logic [PH_W-1:0] T1_INC = PH_W'((T1_LINE_KHZ * 65536) / (CLK_MHZ * 1000));
    logic [PH_W-1:0] ph_q, ph_d;
    logic            edge_seen, line_rise, line_fall;
    assign edge_seen = (pos_s != pos_prev_q) || (!cfg.rx_nrz && (neg_s != neg_prev_q));
    always_comb begin
        ph_d = ph_q + (cfg.e1_mode ? E1_INC : T1_INC);
        if (edge_seen) begin
            ph_d = {2'b01, {(PH_W-2){1'b0}}};
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ph_q       <= '0;
            pos_prev_q <= 1'b0;
            neg_prev_q <= 1'b0;
        end else begin
            ph_q       <= ph_d;
            pos_prev_q <= pos_s;
            neg_prev_q <= neg_s;
        end
    end
    assign line_rise = !ph_q[PH_W-1] && ph_d[PH_W-1] && !edge_seen;
    assign line_fall = ph_q[PH_W-1] && !ph_d[PH_W-1];

    // receive bit decode and frame/multiframe counters
    logic                   rx_bit;
    logic [FRAME_CNT_W-1:0] bit_q, bit_d, frame_len;
    logic [MF_CNT_W-1:0]    mf_q, mf_d, mf_len;
    logic                   aln_prev_q, aln_fall;
    // split phase: a mark on either rail is a one; nrz uses positive only
    assign rx_bit    = cfg.rx_nrz ? pos_s : (pos_s | neg_s);
    assign frame_len = cfg.e1_mode ? FRAME_CNT_W'(E1_FRAME_BITS - 1)
                                   : FRAME_CNT_W'(T1_FRAME_BITS - 1);
    assign mf_len    = cfg.e1_mode ? MF_CNT_W'(MF_FRAMES - 1) : MF_CNT_W'(T1_MF_FRAMES - 1);
    assign aln_fall  = aln_prev_q && !aln_n_s;

    always_comb begin
        bit_d = bit_q;
        mf_d  = mf_q;
        if (line_rise) begin
            // a mode change can leave the count past the shorter frame
            if (bit_q >= frame_len) begin
                bit_d = '0;
                mf_d  = (mf_q == mf_len) ? '0 : mf_q + 1'b1;
            end else begin
                bit_d = bit_q + 1'b1;
            end
        end
        if (aln_fall) begin
            bit_d = '0;
            mf_d  = '0;
        end
    end

    // data link bit select: e1 uses sa bits 4..8 of odd frames, t1 bit 0 of odd frames
    logic       dl_slot;
    logic [2:0] sa_idx;
    assign sa_idx  = bit_q[2:0] - DL_FIRST_BIT_E1;
    assign dl_slot = mf_q[0] && (cfg.e1_mode
                     ? (bit_q[FRAME_CNT_W-1:3] == '0 && bit_q[2:0] >= DL_FIRST_BIT_E1
                        && sa_idx <= cfg.dl_rate)
                     : (bit_q == T1_DL_SLOT_BIT && cfg.dl_rate == DL_RATE_4K));

    // received link bits pass the buffer; ready stalls drop into an overrun flag
    fdlp_rx_word_t in_w, out_w;
    logic          in_v, in_rdy, out_v, out_rdy, ovr_q, ovr_d;
    assign in_w    = '{bit_val: rx_bit, dl_bit: dl_slot};
    assign in_v    = line_rise;
    assign out_rdy = rx_link_ready && line_rise;
    fdlp_buf #(.WIDTH($bits(fdlp_rx_word_t)), .DEPTH(BUF_DEPTH)) u_buf (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (in_v),
        .in_ready  (in_rdy),
        .in_data   (in_w),
        .out_valid (out_v),
        .out_ready (out_rdy),
        .out_data  (out_w)
    );
    assign ovr_d = ovr_q | (in_v && !in_rdy);

    // outputs launched from the line clock rising instant; gapped clock rises and extracted clock falls at line fall
    logic ta_q, ta_d, tb_q, tb_d, rd_q, rd_d, gc_q, gc_d, bp_q, bp_d, xc_q, xc_d;
    logic ls_q, ls_d;
    always_comb begin
        ta_d = ta_q;
        tb_d = tb_q;
        rd_d = rd_q;
        gc_d = gc_q;
        bp_d = bp_q;
        ls_d = ls_q;
        xc_d = line_rise ? 1'b1 : (line_fall ? 1'b0 : xc_q);
        if (line_rise) begin
            if (cfg.nrz) begin
                ta_d = tx_bit;
                tb_d = 1'b0;
            end else begin
                ta_d = tx_bit;
                tb_d = !tx_bit;
            end
            bp_d = cfg.frame_pulse_sel && (bit_q == '0);
        end
        if (line_rise && out_v) begin
            rd_d = out_w.bit_val;
            ls_d = out_w.dl_bit;
        end
        // rising at mid-bit gives the receiver settled data to clock in
        if (line_rise) begin
            gc_d = 1'b0;
        end else if (line_fall) begin
            gc_d = ls_q;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ta_q       <= 1'b0;
            tb_q       <= 1'b0;
            rd_q       <= 1'b0;
            gc_q       <= 1'b0;
            bp_q       <= 1'b0;
            xc_q       <= 1'b0;
            ls_q       <= 1'b0;
            bit_q      <= '0;
            mf_q       <= '0;
            aln_prev_q <= 1'b1;
            ovr_q      <= 1'b0;
        end else begin
            ta_q       <= ta_d;
            tb_q       <= tb_d;
            rd_q       <= rd_d;
            gc_q       <= gc_d;
            bp_q       <= bp_d;
            xc_q       <= xc_d;
            ls_q       <= ls_d;
            bit_q      <= bit_d;
            mf_q       <= mf_d;
            aln_prev_q <= aln_n_s;
            ovr_q      <= ovr_d;
        end
    end

    assign tx_rail_a            = ta_q;
    assign tx_rail_b            = tb_q;
    assign rx_link_serial_out   = rd_q;
    assign rx_link_gapped_clock = gc_q; // rise sits mid-bit on the data
    assign boundary_pulse_out   = bp_q;
    assign extracted_clock      = xc_q;
    assign tx_bit_taken         = line_rise;
    assign rx_overrun           = ovr_q;

    // gapped clock low while no link bit is selected
    property p_gc_low;
        @(posedge clock) disable iff (!rst_n)
        rx_link_gapped_clock |-> (ls_q && !extracted_clock);
    endproperty
    a_gc_low: assert property (p_gc_low) else $error("gapped clock high off slot");

    property p_nrz;
        @(posedge clock) disable iff (!rst_n)
        (line_rise && cfg.nrz) |=> (tx_rail_a == $past(tx_bit) && !tx_rail_b);
    endproperty
    a_nrz: assert property (p_nrz) else $error("nrz rail wrong");

    property p_dual;
        @(posedge clock) disable iff (!rst_n)
        (line_rise && !cfg.nrz) |=> (tx_rail_b == !tx_rail_a);
    endproperty
    a_dual: assert property (p_dual) else $error("rails not complementary");

    property p_align;
        @(posedge clock) disable iff (!rst_n)
        aln_fall |=> (bit_q == '0 && mf_q == '0);
    endproperty
    a_align: assert property (p_align) else $error("align ignored");

    property p_rxd_hold;
        @(posedge clock) disable iff (!rst_n)
        !$past(line_rise) |-> $stable(rx_link_serial_out);
    endproperty
    a_rxd_hold: assert property (p_rxd_hold) else $error("rx data moved off edge");

    property p_fp;
        @(posedge clock) disable iff (!rst_n)
        (line_rise && !cfg.frame_pulse_sel) |=> !boundary_pulse_out;
    endproperty
    a_fp: assert property (p_fp) else $error("frame pulse while unselected");

    property p_rise;
        @(posedge clock) disable iff (!rst_n)
        line_rise |=> extracted_clock;
    endproperty
    a_rise: assert property (p_rise) else $error("line clock not high after rise");

    property p_free;
        @(posedge clock) disable iff (!rst_n)
        (aln_n_s && line_rise && bit_q < frame_len) |=> (bit_q == $past(bit_q) + 1'b1);
    endproperty
    a_free: assert property (p_free) else $error("free-run count broke");
endmodule
`default_nettype wire

// file: verification/fdlp_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module fdlp_far_end (
    // line side
    output logic           rx_line_positive,
    output logic           rx_line_negative,
    input  wire logic      split,
    input  wire logic [9:0] bit_ns,
    // data link receiver
    input  wire logic      rx_link_gapped_clock,
    input  wire logic      rx_link_serial_out
);
    logic [7:0] pat;
    logic       mark;
    logic [7:0] dl_bits;
    int         n_dl = 0;

    initial begin
        pat = 8'hd6;
        mark = 1'b0;
        rx_line_positive = 1'b0;
        rx_line_negative = 1'b0;
        // let the bench set the bit period before the first delay
        #1;
        forever begin
            #(bit_ns);
            if (split) begin
                // ones alternate between the two inputs, zeros leave both low
                rx_line_positive = pat[7] & ~mark;
                rx_line_negative = pat[7] & mark;
                mark = mark ^ pat[7];
            end else begin
                rx_line_positive = pat[7];
                // toggles so that a design reading it in nrz mode is caught
                rx_line_negative = ~rx_line_negative;
            end
            pat = {pat[6:0], pat[7]};
        end
    end

    always @(posedge rx_link_gapped_clock) begin
        n_dl++;
        dl_bits = {dl_bits[6:0], rx_link_serial_out};
    end
endmodule
`default_nettype wire

// file: verification/framer_digital_line_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t mismatch", $time); end end
module framer_digital_line_port_bench;
    import fdlp_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    fdlp_cfg_t   cfg = 8'hf0;
    logic [15:0] tx_pat = 16'hb38e;
    logic        align_n = 1'b1;
    logic        ready = 1'b1;
    logic        split = 1'b0;
    logic [9:0]  bit_ns = 10'h1e8;
    logic        ext_q = 1'b0;
    logic        gap_q = 1'b0;
    logic        bnd_q = 1'b0;
    logic        dl_q = 1'b0;
    logic        tk_q = 1'b0;
    logic        nb_q = 1'b0;
    logic        exp_q = 1'b0;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          since = 0;
    int          armed = 0;
    int          waited = 0;
    wire         taken, rail_a, rail_b, ext_clk, bnd, gap, dl_out, overrun, pos, neg;
    wire         ext_rise = ext_clk & ~ext_q;
    wire         bnd_rise = bnd & ~bnd_q;

    fdlp_port uut (.clock(clock), .rst_n(rst_n), .cfg(cfg), .tx_bit(tx_pat[15]),
        .tx_bit_taken(taken), .rx_line_positive(pos), .rx_line_negative(neg),
        .tx_multiframe_align_n(align_n), .tx_rail_a(rail_a), .tx_rail_b(rail_b),
        .extracted_clock(ext_clk), .boundary_pulse_out(bnd),
        .rx_link_gapped_clock(gap), .rx_link_serial_out(dl_out),
        .rx_link_ready(ready), .rx_overrun(overrun));
    fdlp_far_end far (.rx_line_positive(pos), .rx_line_negative(neg), .split(split),
        .bit_ns(bit_ns), .rx_link_gapped_clock(gap), .rx_link_serial_out(dl_out));

    always #5 clock = ~clock;

    // mode is captured with the bit, since tasks may change cfg at other edges
    always @(negedge clock) begin
        if (tk_q) `CHK(rail_a, exp_q)
        if (nb_q) `CHK(rail_b, ~exp_q)
        if (tk_q && !nb_q) `CHK(rail_b, 1'b0)
        if (gap & ~gap_q) `CHK(ext_clk, 1'b0)
        if (gap & ~gap_q) `CHK(far.dl_bits[0], dl_out)
        if (rst_n && dl_out !== dl_q) `CHK(ext_rise, 1'b1)
        if (ext_rise) since++;
        if (bnd_rise && armed) `CHK(since, cfg.e1_mode ? 256 : 193)
        if (bnd_rise) begin
            since = 0;
            armed = 1;
        end
        if (!rst_n) armed = 0;
        // next bit only once the design has registered the current one
        if (tk_q) tx_pat <= {tx_pat[14:0], tx_pat[15]};
        tk_q <= taken & rst_n;
        nb_q <= taken & rst_n & ~cfg.nrz;
        exp_q <= tx_pat[15];
        ext_q <= ext_clk;
        gap_q <= gap;
        bnd_q <= bnd;
        dl_q <= dl_out;
    end

    task automatic test_done;
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wait_bits(input int n);
        int t;
        for (int i = 0; i < n; i++) begin
            t = 0;
            do begin
                @(negedge clock);
                t++;
            end while (!ext_rise && t < 200);
            waited += t;
            if (t >= 200) `CHK(t, 0)
        end
    endtask

    // any 512 consecutive e1 bits hold exactly one odd frame of link slots
    task automatic t_dl_rate(input int exp);
        int n0;
        n0 = far.n_dl;
        wait_bits(512);
        `CHK(far.n_dl - n0, exp)
    endtask

    task automatic t_rx(input int lo, input int hi);
        logic [23:0] w;
        wait_bits(1);
        waited = 0;
        wait_bits(8);
        `CHK(waited >= lo && waited <= hi, 1'b1)
        for (int i = 0; i < 24; i++) begin
            wait_bits(1);
            w[i] = dl_out;
        end
        for (int i = 0; i < 16; i++) `CHK(w[i], w[i + 8])
        `CHK($countones(w[7:0]), 5)
    endtask

    task automatic t_align;
        int t;
        cfg.dl_rate = DL_RATE_20K;
        cfg.nrz = 1'b0;
        cfg.crc_mf = 1'b1;
        t = 0;
        do begin
            @(negedge clock);
            t++;
        end while (!bnd_rise && t < 15000);
        `CHK(bnd_rise, 1'b1)
        // far from the natural boundary, so an early pulse proves the realignment
        wait_bits(100);
        armed = 0;
        align_n = 1'b0;
        t = 0;
        do begin
            @(negedge clock);
            t++;
        end while (!bnd_rise && t < 250);
        `CHK(bnd_rise, 1'b1)
        align_n = 1'b1;
        wait_bits(260);
    endtask

    task automatic t_t1;
        armed = 0;
        cfg = 8'h50;
        split = 1'b1;
        bit_ns = 10'h288;
        wait_bits(30);
        t_rx(510, 526);
    endtask

    task automatic t_stall;
        `CHK(overrun, 1'b0)
        ready = 1'b0;
        wait_bits(8);
        `CHK(overrun, 1'b1)
        ready = 1'b1;
        wait_bits(4);
        `CHK(overrun, 1'b1)
        // step off the rail check edge before pulling reset
        @(negedge clock);
        rst_n = 1'b0;
        @(negedge clock);
        `CHK({overrun, rail_a, gap}, 3'h0)
        @(negedge clock);
        rst_n = 1'b1;
    endtask

    initial begin
        repeat (95000) @(posedge clock);
        n_mismatch++;
        test_done;
    end

    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        wait_bits(20);
        t_dl_rate(1);
        t_rx(382, 398);
        t_align;
        t_dl_rate(5);
        t_t1;
        t_stall;
        test_done;
    end
endmodule
`default_nettype wire
